/* File: core_special_registers.sv */
// core special registers behind a classic wishbone slave
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - pc low byte is read and written directly by software
// - pc upper latch holds seven bits buffering the upper program counter
// - timeout flag sets at power-up, clear-watchdog or sleep
// - timeout flag clears on watchdog timer time-out
// - power-down flag sets at power-up or clear-watchdog
// - power-down flag clears on sleep
// - power-on reset sets both power flags; other resets use reset condition
// - zero flag follows whether the alu result is zero on logic, add and subtract
// - digit carry flag is carry out of bit three on add and subtract
// - carry flag is carry out of the top bit on add and subtract
// - subtraction adds two's complement, so carries read as inverted borrow
// - rotate through carry loads carry from the shifted-out source bit
// - power-on reset clears zero, digit carry, carry; other resets keep them
// - pointer zero addresses data for indirect port zero
// - pointer one addresses data for indirect port one
// - each pointer is reachable as separate high and low bytes
// - bank number holds six bits for the top of direct addresses
// - indirect port accesses are redirected to the pointer's address
// - pointer aimed at an indirect port reads zero, write suppressed
module core_special_registers
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic power_on_reset,
  input wire logic other_reset,
  input wire logic other_reset_timeout,
  input wire logic other_reset_power_down,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire core_sfr_pkg::alu_event_t alu_event,
  input wire core_sfr_pkg::power_event_t power_event,
  input wire logic [7:0] mem_rdata,
  output core_sfr_pkg::mem_req_t mem_req,
  output logic [7:0] pc_low_out,
  output logic [6:0] pc_upper_out,
  output logic [5:0] bank_out,
  output logic [7:0] accumulator_out,
  output logic [4:0] flags_out
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0] pcl_q, pcl_d;
  logic [7:0] flags_q, flags_d;
  logic [15:0] ptr0_q, ptr0_d;
  logic [15:0] ptr1_q, ptr1_d;
  logic [7:0] bank_q, bank_d;
  logic [7:0] acc_q, acc_d;
  logic [7:0] upper_q, upper_d;
  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  core_sfr_pkg::mem_req_t mreq_q, mreq_d;

  ////////////////////////////////////////////////////////////////////////////
  // indirect reads: pointer goes out first, memory data is taken one cycle later
  typedef enum logic [1:0]
  {
    ind_idle = 2'b01,
    ind_fetch = 2'b10
  } ind_state_t;

  ind_state_t ind_q, ind_d;

  // true when an address names one of the two indirect ports
  function automatic logic is_indirect(input logic [15:0] a);
    logic [15:0] port_zero;
    logic [15:0] port_one;
    port_zero = {9'h000, core_sfr_pkg::ofs_indirect_port_zero};
    port_one = {9'h000, core_sfr_pkg::ofs_indirect_port_one};
    is_indirect = (a == port_zero) || (a == port_one);
  endfunction : is_indirect

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  logic req;
  logic wr_take;
  logic [6:0] ofs;
  logic lane0;
  logic [7:0] wbyte;

  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr_take = req && wb_we_i && lane0;
  assign ofs = wb_adr_i[8:2];
  assign lane0 = wb_sel_i[0];
  assign wbyte = wb_dat_i[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // alu flag computation
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [7:0] addend;
  logic carry_in;

  always_comb
  begin
    // subtract adds two's complement of the second operand
    addend = (alu_event.op == core_sfr_pkg::op_sub) ? ~alu_event.operand_b
                                                    : alu_event.operand_b;
    carry_in = (alu_event.op == core_sfr_pkg::op_sub);
    sum9 = {1'b0, alu_event.operand_a} + {1'b0, addend} + {8'h00, carry_in};
    sum5 = {1'b0, alu_event.operand_a[3:0]} + {1'b0, addend[3:0]} + {4'h0, carry_in};
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    pcl_d = pcl_q;
    flags_d = flags_q;
    ptr0_d = ptr0_q;
    ptr1_d = ptr1_q;
    bank_d = bank_q;
    acc_d = acc_q;
    upper_d = upper_q;
    ack_d = 1'b0;
    rdata_d = rdata_q;
    mreq_d = '0;
    // a read that the master abandons falls back to idle
    ind_d = ind_idle;

    // datapath flag updates
    case (alu_event.op)
      core_sfr_pkg::op_logic:
      begin
        flags_d[core_sfr_pkg::bit_zero] = (alu_event.operand_a == 8'h00);
      end
      core_sfr_pkg::op_add, core_sfr_pkg::op_sub:
      begin
        flags_d[core_sfr_pkg::bit_zero] = (sum9[7:0] == 8'h00);
        flags_d[core_sfr_pkg::bit_digit_carry] = sum5[4];
        flags_d[core_sfr_pkg::bit_carry] = sum9[8];
      end
      core_sfr_pkg::op_rot_right:
      begin
        flags_d[core_sfr_pkg::bit_carry] = alu_event.operand_a[0];
      end
      core_sfr_pkg::op_rot_left:
      begin
        flags_d[core_sfr_pkg::bit_carry] = alu_event.operand_a[7];
      end
      default:
      begin
        flags_d = flags_d;
      end
    endcase

    // power events; watchdog time-out outranks clear-watchdog and sleep in the same cycle
    if (power_event.clear_watchdog)
    begin
      flags_d[core_sfr_pkg::bit_timeout] = 1'b1;
      flags_d[core_sfr_pkg::bit_power_down] = 1'b1;
    end
    if (power_event.sleep)
    begin
      flags_d[core_sfr_pkg::bit_timeout] = 1'b1;
      flags_d[core_sfr_pkg::bit_power_down] = 1'b0;
    end
    if (power_event.watchdog_timeout)
    begin
      flags_d[core_sfr_pkg::bit_timeout] = 1'b0;
    end

    // wishbone slave: one-cycle ack, byte lane 0 carries the data
    if (req)
    begin
      ack_d = 1'b1;
      rdata_d = core_sfr_pkg::rst_wb_data;
      if (wb_adr_i[31:9] == 23'h000000)
      begin
        case (ofs)
          core_sfr_pkg::ofs_indirect_port_zero:
          begin
            if (is_indirect(ptr0_q))
            begin
              rdata_d = core_sfr_pkg::rst_wb_data;
            end
            else if (wb_we_i)
            begin
              mreq_d.valid = lane0;
              mreq_d.write = wr_take;
              mreq_d.addr = ptr0_q;
              mreq_d.wdata = wbyte;
            end
            else if (ind_q == ind_idle)
            begin
              ack_d = 1'b0;
              ind_d = ind_fetch;
              mreq_d.valid = 1'b1;
              mreq_d.addr = ptr0_q;
            end
            else
            begin
              // memory has held the pointer for one cycle
              rdata_d = {24'h000000, mem_rdata};
            end
          end
          core_sfr_pkg::ofs_indirect_port_one:
          begin
            if (is_indirect(ptr1_q))
            begin
              rdata_d = core_sfr_pkg::rst_wb_data;
            end
            else if (wb_we_i)
            begin
              mreq_d.valid = lane0;
              mreq_d.write = wr_take;
              mreq_d.addr = ptr1_q;
              mreq_d.wdata = wbyte;
            end
            else if (ind_q == ind_idle)
            begin
              ack_d = 1'b0;
              ind_d = ind_fetch;
              mreq_d.valid = 1'b1;
              mreq_d.addr = ptr1_q;
            end
            else
            begin
              // memory has held the pointer for one cycle
              rdata_d = {24'h000000, mem_rdata};
            end
          end
          core_sfr_pkg::ofs_pc_low_byte:
          begin
            rdata_d = {24'h000000, pcl_q};
            if (wr_take)
            begin
              pcl_d = wbyte;
            end
          end
          core_sfr_pkg::ofs_arith_power_flags:
          begin
            rdata_d = {24'h000000, flags_q & core_sfr_pkg::flags_mask};
            if (wr_take)
            begin
              // only zero, digit carry and carry are writable
              flags_d[2:0] = wbyte[2:0];
            end
          end
          core_sfr_pkg::ofs_pointer_zero_low:
          begin
            rdata_d = {24'h000000, ptr0_q[7:0]};
            if (wr_take)
            begin
              ptr0_d[7:0] = wbyte;
            end
          end
          core_sfr_pkg::ofs_pointer_zero_high:
          begin
            rdata_d = {24'h000000, ptr0_q[15:8]};
            if (wr_take)
            begin
              ptr0_d[15:8] = wbyte;
            end
          end
          core_sfr_pkg::ofs_pointer_one_low:
          begin
            rdata_d = {24'h000000, ptr1_q[7:0]};
            if (wr_take)
            begin
              ptr1_d[7:0] = wbyte;
            end
          end
          core_sfr_pkg::ofs_pointer_one_high:
          begin
            rdata_d = {24'h000000, ptr1_q[15:8]};
            if (wr_take)
            begin
              ptr1_d[15:8] = wbyte;
            end
          end
          core_sfr_pkg::ofs_bank_number:
          begin
            rdata_d = {24'h000000, bank_q};
            if (wr_take)
            begin
              bank_d = wbyte & core_sfr_pkg::bank_mask;
            end
          end
          core_sfr_pkg::ofs_working_accumulator:
          begin
            rdata_d = {24'h000000, acc_q};
            if (wr_take)
            begin
              acc_d = wbyte;
            end
          end
          core_sfr_pkg::ofs_pc_upper_latch:
          begin
            rdata_d = {24'h000000, upper_q};
            if (wr_take)
            begin
              upper_d = wbyte & core_sfr_pkg::upper_latch_mask;
            end
          end
          default:
          begin
            rdata_d = core_sfr_pkg::rst_wb_data;
          end
        endcase
      end
    end

    // power-on or brown-out reset
    if (power_on_reset)
    begin
      flags_d = core_sfr_pkg::rst_flags;
    end
    else if (other_reset)
    begin
      flags_d[core_sfr_pkg::bit_timeout] = other_reset_timeout;
      flags_d[core_sfr_pkg::bit_power_down] = other_reset_power_down;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pcl_q <= core_sfr_pkg::rst_pc_low_byte;
      flags_q <= core_sfr_pkg::rst_flags;
      ptr0_q <= core_sfr_pkg::rst_pointer;
      ptr1_q <= core_sfr_pkg::rst_pointer;
      bank_q <= core_sfr_pkg::rst_bank_number;
      acc_q <= core_sfr_pkg::rst_working_accumulator;
      upper_q <= core_sfr_pkg::rst_pc_upper_latch;
      ack_q <= 1'b0;
      rdata_q <= core_sfr_pkg::rst_wb_data;
      mreq_q <= '0;
      ind_q <= ind_idle;
    end
    else
    begin
      pcl_q <= pcl_d;
      flags_q <= flags_d;
      ptr0_q <= ptr0_d;
      ptr1_q <= ptr1_d;
      bank_q <= bank_d;
      acc_q <= acc_d;
      upper_q <= upper_d;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      mreq_q <= mreq_d;
      ind_q <= ind_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;
  assign mem_req = mreq_q;
  assign pc_low_out = pcl_q;
  assign pc_upper_out = upper_q[6:0];
  assign bank_out = bank_q[5:0];
  assign accumulator_out = acc_q;
  assign flags_out = flags_q[4:0];

endmodule : core_special_registers

`default_nettype wire

/* File: core_sfr_pkg.sv */
// package: offsets, fields, reset values and carriers for the core special registers
package core_sfr_pkg;

  // register offsets (word indices of the core special registers, taken from bus address bits 8:2)
  localparam logic [6:0] ofs_indirect_port_zero = 7'h00;
  localparam logic [6:0] ofs_indirect_port_one = 7'h01;
  localparam logic [6:0] ofs_pc_low_byte = 7'h02;
  localparam logic [6:0] ofs_arith_power_flags = 7'h03;
  localparam logic [6:0] ofs_pointer_zero_low = 7'h04;
  localparam logic [6:0] ofs_pointer_zero_high = 7'h05;
  localparam logic [6:0] ofs_pointer_one_low = 7'h06;
  localparam logic [6:0] ofs_pointer_one_high = 7'h07;
  localparam logic [6:0] ofs_bank_number = 7'h08;
  localparam logic [6:0] ofs_working_accumulator = 7'h09;
  localparam logic [6:0] ofs_pc_upper_latch = 7'h0a;

  // flag positions within arith_power_flags
  localparam int bit_carry = 0;
  localparam int bit_digit_carry = 1;
  localparam int bit_zero = 2;
  localparam int bit_power_down = 3;
  localparam int bit_timeout = 4;

  // implemented bit masks
  localparam logic [7:0] flags_mask = 8'h1f;
  localparam logic [7:0] upper_latch_mask = 8'h7f;
  localparam logic [7:0] bank_mask = 8'h3f;

  // reset values
  localparam logic [7:0] rst_pc_low_byte = 8'h00;
  localparam logic [7:0] rst_flags = 8'h18;
  localparam logic [15:0] rst_pointer = 16'h0000;
  localparam logic [7:0] rst_bank_number = 8'h00;
  localparam logic [7:0] rst_working_accumulator = 8'h00;
  localparam logic [7:0] rst_pc_upper_latch = 8'h00;
  localparam logic [31:0] rst_wb_data = 32'h0000_0000;

  // alu operation classes reported by the datapath
  typedef enum logic [2:0]
  {
    op_none = 3'h0,
    op_logic = 3'h1,
    op_add = 3'h2,
    op_sub = 3'h3,
    op_rot_right = 3'h4,
    op_rot_left = 3'h5
  } alu_op_t;

  // one datapath result to fold into the flags
  typedef struct packed
  {
    alu_op_t op;
    logic [7:0] operand_a;
    logic [7:0] operand_b;
  } alu_event_t;

  // power / watchdog events from the instruction decoder
  typedef struct packed
  {
    logic clear_watchdog;
    logic sleep;
    logic watchdog_timeout;
  } power_event_t;

  // indirect data redirect toward data memory
  typedef struct packed
  {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mem_req_t;

endpackage : core_sfr_pkg

/* File: core_special_registers_assertions.sv */
// checker: port assertions of the core special registers
`timescale 1ns/1ps
`default_nettype none
module core_special_registers_assertions
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic power_on_reset,
  input wire logic other_reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire core_sfr_pkg::alu_event_t alu_event,
  input wire core_sfr_pkg::power_event_t power_event,
  input wire core_sfr_pkg::mem_req_t mem_req,
  input wire logic [4:0] flags_out
);
  logic [8:0] sum;
  logic [4:0] nib;
  logic [2:0] add_exp;
  logic calm;
  always_comb
  begin
    sum = {1'b0, alu_event.operand_a} + {1'b0, alu_event.operand_b};
    nib = {1'b0, alu_event.operand_a[3:0]} + {1'b0, alu_event.operand_b[3:0]};
    add_exp = {sum[7:0] == 8'h00, nib[4], sum[8]};
    calm = !power_on_reset && !other_reset;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  chk_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |-> ##[1:2] wb_ack_o)
    else $error("ack missing after request");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_read_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  chk_add_flags: assert property (alu_event.op == core_sfr_pkg::op_add && calm
    && !(wb_cyc_i && wb_stb_i && wb_we_i) |=> flags_out[2:0] == $past(add_exp))
    else $error("add flags wrong");
  chk_sleep_flags: assert property (power_event == 3'b010 && calm
    |=> flags_out[4:3] == 2'b10)
    else $error("sleep flags wrong");
  chk_clear_watchdog_instr_flags: assert property (power_event == 3'b100 && calm
    |=> flags_out[4:3] == 2'b11)
    else $error("clear watchdog flags wrong");
  chk_wdt_timeout: assert property (power_event.watchdog_timeout && calm |=> !flags_out[4])
    else $error("timeout flag not cleared");
  chk_por_flags: assert property (power_on_reset |=> flags_out == 5'h18)
    else $error("power-on flags wrong");
  chk_req_pulse: assert property (mem_req.valid |=> !mem_req.valid)
    else $error("memory request longer than one cycle");
  chk_read_fetch: assert property (mem_req.valid && !mem_req.write
    |-> !wb_ack_o ##1 wb_ack_o)
    else $error("indirect read not answered after fetch");
  cover property (alu_event.op == core_sfr_pkg::op_add);
  cover property (power_event.sleep);
  cover property (mem_req.valid && mem_req.write);
endmodule : core_special_registers_assertions
`default_nettype wire

/* File: data_memory_model.sv */
// partner: data memory behind the indirect ports
`timescale 1ns/1ps
`default_nettype none
module data_memory_model
#(
  parameter logic [7:0] read_value = 8'h5a
)
(
  input wire logic sys_clk,
  input wire core_sfr_pkg::mem_req_t mem_req,
  output logic [7:0] mem_rdata,
  output logic [7:0] last_wdata
);
  // low address byte selects a cell; cells start as address xor pattern
  logic [7:0] cells [256];
  assign mem_rdata = cells[mem_req.addr[7:0]];
  initial
  begin
    last_wdata = 8'h00;
    for (int i = 0; i < 256; i++)
      cells[i] = i[7:0] ^ read_value;
  end
  always @(posedge sys_clk)
  begin
    if (mem_req.valid && mem_req.write)
    begin
      cells[mem_req.addr[7:0]] <= mem_req.wdata;
      last_wdata <= mem_req.wdata;
    end
  end
endmodule : data_memory_model
`default_nettype wire

/* File: core_special_registers_test.sv */
// testbench: core special registers
`timescale 1ns/1ps
`default_nettype none
module core_special_registers_test;
  logic sys_clk = 1'b0, rst = 1'b1, power_on_reset = 1'b0, other_reset = 1'b0;
  logic other_reset_timeout = 1'b0, other_reset_power_down = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [3:0] wb_sel_i = 4'h1;
  core_sfr_pkg::alu_event_t alu_event = '0;
  core_sfr_pkg::power_event_t power_event = '0;
  core_sfr_pkg::mem_req_t mem_req, seen;
  logic [7:0] mem_rdata, pc_low_out, accumulator_out, last_wdata;
  logic [6:0] pc_upper_out;
  logic [5:0] bank_out;
  logic [4:0] flags_out;
  int errors = 0, compares = 0;
  always #2.5 sys_clk = ~sys_clk;
  core_special_registers i_core_special_registers (.sys_clk, .rst, .power_on_reset,
    .other_reset, .other_reset_timeout, .other_reset_power_down, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .alu_event,
    .power_event, .mem_rdata, .mem_req, .pc_low_out, .pc_upper_out, .bank_out,
    .accumulator_out, .flags_out);
  data_memory_model i_data_memory_model (.sys_clk, .mem_req, .mem_rdata, .last_wdata);
  ////////////////////////////////////////////////////////////////////////////////
  task check(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task summarize();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  task wb(input logic we, input logic [6:0] ix, input logic [7:0] d);
    seen = '0;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {23'h0, ix, 2'b00};
    wb_dat_i <= {24'h0, d};
    do
    begin
      @(posedge sys_clk);
      if (mem_req.valid)
        seen = mem_req;
    end
    while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task rchk(input logic [6:0] ix, input logic [7:0] e);
    wb(1'b0, ix, 8'h00);
    check("read", {8'h00, e}, rd[15:0]);
  endtask : rchk
  task ev(input logic [2:0] pw, input logic [18:0] al, input logic [2:0] rs);
    @(posedge sys_clk);
    power_event <= pw;
    alu_event <= al;
    {power_on_reset, other_reset, other_reset_timeout} <= rs;
    other_reset_power_down <= 1'b1;
    @(posedge sys_clk);
    power_event <= '0;
    alu_event <= '0;
    {power_on_reset, other_reset} <= 2'b00;
    @(posedge sys_clk);
  endtask : ev
  ////////////////////////////////////////////////////////////////////////////////
  task test_regs();
    logic [6:0] ix [9] = '{7'h02, 7'h0a, 7'h08, 7'h09, 7'h04, 7'h05, 7'h06, 7'h07, 7'h0b};
    logic [7:0] wv [9] = '{8'ha5, 8'hff, 8'hff, 8'hc3, 8'h34, 8'h12, 8'h78, 8'h56, 8'h99};
    logic [7:0] e [9] = '{8'ha5, 8'h7f, 8'h3f, 8'hc3, 8'h34, 8'h12, 8'h78, 8'h56, 8'h00};
    for (int i = 2; i <= 11; i++)
      rchk(i[6:0], i == 3 ? 8'h18 : 8'h00);
    for (int i = 0; i < 9; i++)
    begin
      wb(1'b1, ix[i], wv[i]);
      rchk(ix[i], e[i]);
    end
    wb(1'b1, 7'h03, 8'hff);
    rchk(7'h03, 8'h1f);
    check("upper", 16'h007f, {9'h0, pc_upper_out});
    check("bank", 16'h003f, {10'h0, bank_out});
    check("low", 16'h00a5, {8'h0, pc_low_out});
    check("acc", 16'h00c3, {8'h0, accumulator_out});
  endtask : test_regs
  task test_alu();
    logic [2:0] op [8] = '{3'h2, 3'h2, 3'h3, 3'h3, 3'h1, 3'h4, 3'h5, 3'h5};
    logic [7:0] a [8] = '{8'h0f, 8'hff, 8'h05, 8'h00, 8'h00, 8'h01, 8'h7f, 8'h80};
    logic [7:0] b [8] = '{8'h01, 8'h01, 8'h03, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [2:0] e [8] = '{3'h2, 3'h7, 3'h3, 3'h0, 3'h4, 3'h1, 3'h0, 3'h1};
    logic [2:0] m [8] = '{3'h7, 3'h7, 3'h7, 3'h7, 3'h4, 3'h1, 3'h1, 3'h1};
    for (int i = 0; i < 8; i++)
    begin
      ev(3'h0, {op[i], a[i], b[i]}, 3'h0);
      check("alu", {13'h0, e[i]}, {13'h0, flags_out[2:0] & m[i]});
    end
  endtask : test_alu
  task test_power();
    wb(1'b1, 7'h03, 8'h05);
    ev(3'h1, '0, 3'h0);
    check("timeout", 16'h0, {15'h0, flags_out[4]});
    ev(3'h2, '0, 3'h0);
    check("sleep", 16'h0015, {11'h0, flags_out});
    ev(3'h4, '0, 3'h0);
    check("clear_watchdog_instr", 16'h001d, {11'h0, flags_out});
    ev(3'h0, '0, 3'h2);
    check("other", 16'h000d, {11'h0, flags_out});
    ev(3'h0, '0, 3'h4);
    check("por", 16'h0018, {11'h0, flags_out});
  endtask : test_power
  task test_indirect();
    wb(1'b1, 7'h06, 8'h34);
    wb(1'b1, 7'h07, 8'h12);
    wb(1'b1, 7'h01, 8'h3c);
    check("req", 16'h0003, {14'h0, seen.valid, seen.write});
    check("addr", 16'h1234, seen.addr);
    wb(1'b1, 7'h04, 8'h55);
    check("wdata", 16'h003c, {8'h0, last_wdata});
    wb(1'b1, 7'h05, 8'h00);
    rchk(7'h00, 8'h0f);
    check("addr", 16'h0055, seen.addr);
    rchk(7'h01, 8'h3c);
    wb(1'b1, 7'h04, 8'h34);
    rchk(7'h00, 8'h3c);
    wb(1'b1, 7'h04, 8'h01);
    rchk(7'h00, 8'h00);
    check("req", 16'h0000, {15'h0, seen.valid});
    wb(1'b1, 7'h00, 8'h77);
    check("req", 16'h0000, {15'h0, seen.valid});
  endtask : test_indirect
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    test_regs();
    test_alu();
    test_power();
    test_indirect();
    summarize();
  end
  initial
  begin
    #100000;
    errors++;
    summarize();
  end
endmodule : core_special_registers_test
bind core_special_registers core_special_registers_assertions i_chk (.sys_clk(sys_clk),
  .rst(rst), .power_on_reset(power_on_reset), .other_reset(other_reset),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .alu_event(alu_event), .power_event(power_event),
  .mem_req(mem_req), .flags_out(flags_out));
`default_nettype wire
